// >>> cie_afe_model.sv
// line-side front end model that drives the event logic inputs
`default_nettype none
module cie_afe_model #(
  parameter int BAUD = 16
) (
  input  wire logic              core_clk,
  output var  cie_pkg::cie_afe_t afe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // idle line: only the demodulated bit rests high
  // ****************************************************************
  initial afe = 11'h001;
  // ****************************************************************
  // 8n1 frame, lsb first, one baud period per bit
  // ****************************************************************
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk);
      afe.fsk_demod_bit <= f[i];
      repeat (BAUD - 1) @(posedge core_clk);
    end
  endtask
endmodule // cie_afe_model
`default_nettype wire

// >>> cie_event_logic.sv
// caller id event logic: enables, guard timers, fsk receiver, flags
// Function
// - separate enables for fsk, alert, dual tone
// - global enable gates all three detectors
// - ring detector always active
// - ring envelope rise sets ring flag
// - raw alert rise restarts guard timer at zero
// - guard timer steps every 0.858 ms tick
// - count equals present guard: stop, qualify
// - qualified alert rise sets sticky alert flag
// - absence qualified likewise with absent guard
// - qualified alert bit is readable in status bit 0
// - dual tone uses same guard qualification
// - decoded dual tone sets valid, stores code
// - dual tone valid rise sets sticky flag
// - config two bit 4 selects tone mode
// - tone mode group bits follow energy one clock later
// - carrier detect with 8 ms hysteresis
// - serial bit and bit clock at 1200 baud
// - full byte loads data, sets byte ready
// - byte ready rise sets sticky flag
`default_nettype none
module cie_event_logic #(
  parameter int GUARD_TICK_CYCLES = cie_pkg::GUARD_TICK_CYC,
  parameter int CARRIER_CYCLES    = cie_pkg::CARRIER_CYC,
  parameter int BAUD_CYCLES       = cie_pkg::BAUD_CYC
) (
  input  wire  logic             core_clk,
  input  wire  logic             nrst,
  input  wire  cie_pkg::cie_bus_t bus,
  output logic [7:0]             rd_data,
  input  wire  cie_pkg::cie_afe_t afe,
  output logic                   combined_irq_flag,
  output logic                   fsk_decoder_on,
  output logic                   alert_on,
  output logic                   dual_tone_on
);

  // ****************************************************************
  // control registers
  // ****************************************************************
  logic [7:0] ctrl_reg;
  logic [7:0] alert_present_guard_reg;
  logic [7:0] alert_absent_guard_reg;
  logic [7:0] dual_tone_present_guard_reg;
  logic [7:0] dual_tone_absent_guard_reg;
  logic [7:0] dual_tone_config_two_reg;
  logic       tone_mode;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctrl_reg                    <= cie_pkg::RST_BYTE;
      alert_present_guard_reg     <= cie_pkg::RST_BYTE;
      alert_absent_guard_reg      <= cie_pkg::RST_BYTE;
      dual_tone_present_guard_reg <= cie_pkg::RST_BYTE;
      dual_tone_absent_guard_reg  <= cie_pkg::RST_BYTE;
      dual_tone_config_two_reg    <= cie_pkg::RST_BYTE;
    end else if (bus.wr) begin
      if (bus.addr == cie_pkg::ADDR_CTRL) begin
        ctrl_reg <= bus.wdata;
      end else if (bus.addr == cie_pkg::ADDR_AL_PT) begin
        alert_present_guard_reg <= bus.wdata;
      end else if (bus.addr == cie_pkg::ADDR_AL_AT) begin
        alert_absent_guard_reg <= bus.wdata;
      end else if (bus.addr == cie_pkg::ADDR_DT_PT) begin
        dual_tone_present_guard_reg <= bus.wdata;
      end else if (bus.addr == cie_pkg::ADDR_DT_AT) begin
        dual_tone_absent_guard_reg <= bus.wdata;
      end else if (bus.addr == cie_pkg::ADDR_DT_CFG2) begin
        dual_tone_config_two_reg <= bus.wdata;
      end
    end
  end

  // ring path never looks at these enables
  assign fsk_decoder_on = ctrl_reg[cie_pkg::CTRL_FSK_EN]
                        & ctrl_reg[cie_pkg::CTRL_GLOBAL];
  assign alert_on       = ctrl_reg[cie_pkg::CTRL_ALERT_EN]
                        & ctrl_reg[cie_pkg::CTRL_GLOBAL];
  assign dual_tone_on   = ctrl_reg[cie_pkg::CTRL_DT_EN]
                        & ctrl_reg[cie_pkg::CTRL_GLOBAL];
  assign tone_mode = dual_tone_config_two_reg[cie_pkg::CFG2_TONE_MODE];

  // ****************************************************************
  // guard tick divider
  // ****************************************************************
  logic [19:0] tick_cnt_reg;
  logic        tick;

  assign tick = (tick_cnt_reg == 20'(GUARD_TICK_CYCLES - 1));
  always_ff @(posedge core_clk) begin
    if (!nrst || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 20'h00001;
    end
  end

  // ****************************************************************
  // guard timers: 0 alert, 1 dual tone
  // ****************************************************************
  logic [1:0] g_raw;
  logic [1:0] g_en;
  logic [1:0] g_raw_d_reg;
  logic [1:0] g_run_reg;
  logic [1:0] g_q_reg;
  logic [7:0] g_cnt_reg [2];
  logic [7:0] g_pt [2];
  logic [7:0] g_at [2];

  assign g_raw = {afe.dual_tone_raw & ~tone_mode, afe.alert_tone_raw};
  assign g_en  = {dual_tone_on, alert_on};
  assign g_pt[0] = alert_present_guard_reg;
  assign g_at[0] = alert_absent_guard_reg;
  assign g_pt[1] = dual_tone_present_guard_reg;
  assign g_at[1] = dual_tone_absent_guard_reg;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_guard
      logic [7:0] target;
      assign target = g_raw_d_reg[gi] ? g_pt[gi] : g_at[gi];
      always_ff @(posedge core_clk) begin
        if (!nrst || !g_en[gi]) begin
          g_raw_d_reg[gi] <= 1'b0;
          g_run_reg[gi]   <= 1'b0;
          g_q_reg[gi]     <= 1'b0;
          g_cnt_reg[gi]   <= '0;
        end else begin
          g_raw_d_reg[gi] <= g_raw[gi];
          if (g_raw[gi] != g_raw_d_reg[gi]) begin
            g_cnt_reg[gi] <= '0;
            g_run_reg[gi] <= 1'b1;
          end else if (tick && g_run_reg[gi]) begin
            if (g_cnt_reg[gi] == target) begin
              g_run_reg[gi] <= 1'b0;
              g_q_reg[gi]   <= g_raw_d_reg[gi];
            end else begin
              g_cnt_reg[gi] <= g_cnt_reg[gi] + 8'h01;
            end
          end
        end
      end
    end
  endgenerate

  logic alert_tone_qualified;
  logic dual_tone_valid;
  assign alert_tone_qualified = g_q_reg[0];
  assign dual_tone_valid      = g_q_reg[1];

  // ****************************************************************
  // dual tone data
  // ****************************************************************
  logic [3:0] dt_code_reg;
  logic       high_group_present;
  logic       low_group_present;
  logic       dt_q_d_reg;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      dt_code_reg <= '0;
    end else if (g_guard[1].target == g_cnt_reg[1] && tick
                 && g_run_reg[1] && g_raw_d_reg[1] && g_raw[1]) begin
      dt_code_reg <= afe.dual_tone_code;
    end
  end

  // group bits are not guarded: meant for fast polling only
  always_ff @(posedge core_clk) begin
    if (!nrst || !(dual_tone_on && tone_mode)) begin
      high_group_present <= 1'b0;
      low_group_present  <= 1'b0;
    end else begin
      high_group_present <= afe.high_energy;
      low_group_present  <= afe.low_energy;
    end
  end

  // ****************************************************************
  // carrier detect
  // ****************************************************************
  logic [19:0] cd_cnt_reg;
  logic        carrier_detect;
  logic        cd_done;

  // release needs one cycle beyond the 8 ms to be strictly greater
  assign cd_done = carrier_detect
                 ? (cd_cnt_reg == 20'(CARRIER_CYCLES))
                 : (cd_cnt_reg == 20'(CARRIER_CYCLES - 1));
  always_ff @(posedge core_clk) begin
    if (!nrst || !fsk_decoder_on) begin
      cd_cnt_reg     <= '0;
      carrier_detect <= 1'b0;
    end else if (afe.fsk_band_energy == carrier_detect) begin
      cd_cnt_reg <= '0;
    end else if (cd_done) begin
      cd_cnt_reg     <= '0;
      carrier_detect <= ~carrier_detect;
    end else begin
      cd_cnt_reg <= cd_cnt_reg + 20'h00001;
    end
  end

  // ****************************************************************
  // fsk serial receiver
  // ****************************************************************
  cie_pkg::cie_rx_state_t rx_state_reg;
  logic [16:0] baud_cnt_reg;
  logic [2:0]  bit_idx_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  fsk_data_register;
  logic        fsk_byte_ready;
  logic        fsk_serial_bit;
  logic        fsk_bit_clock;
  logic        half_bit;
  logic        full_bit;

  assign half_bit = (baud_cnt_reg == 17'(BAUD_CYCLES / 2 - 1));
  assign full_bit = (baud_cnt_reg == 17'(BAUD_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (!nrst || !fsk_decoder_on) begin
      rx_state_reg      <= cie_pkg::RX_IDLE;
      baud_cnt_reg      <= '0;
      bit_idx_reg       <= '0;
      shift_reg         <= '0;
      fsk_byte_ready    <= 1'b0;
    end else begin
      baud_cnt_reg <= baud_cnt_reg + 17'h00001;
      case (rx_state_reg)
        cie_pkg::RX_IDLE: begin
          baud_cnt_reg <= '0;
          if (!afe.fsk_demod_bit) begin
            rx_state_reg   <= cie_pkg::RX_START;
            fsk_byte_ready <= 1'b0;
          end
        end
        cie_pkg::RX_START: begin
          if (half_bit) begin
            baud_cnt_reg <= '0;
            bit_idx_reg  <= '0;
            rx_state_reg <= afe.fsk_demod_bit ? cie_pkg::RX_IDLE
                                              : cie_pkg::RX_DATA;
          end
        end
        cie_pkg::RX_DATA: begin
          if (full_bit) begin
            baud_cnt_reg <= '0;
            shift_reg    <= {afe.fsk_demod_bit, shift_reg[7:1]};
            bit_idx_reg  <= bit_idx_reg + 3'h1;
            if (bit_idx_reg == cie_pkg::LAST_BIT) begin
              rx_state_reg <= cie_pkg::RX_STOP;
            end
          end
        end
        cie_pkg::RX_STOP: begin
          if (full_bit) begin
            rx_state_reg <= cie_pkg::RX_IDLE;
            if (afe.fsk_demod_bit) begin
              fsk_byte_ready <= 1'b1;
            end
          end
        end
        default: rx_state_reg <= cie_pkg::RX_IDLE;
      endcase
    end
  end

  // data register survives a decoder disable so software can still read
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      fsk_data_register <= cie_pkg::RST_BYTE;
    end else if (rx_state_reg == cie_pkg::RX_STOP && full_bit
                 && afe.fsk_demod_bit && fsk_decoder_on) begin
      fsk_data_register <= shift_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst || !fsk_decoder_on) begin
      fsk_serial_bit <= 1'b1;
      fsk_bit_clock  <= 1'b0;
    end else begin
      fsk_serial_bit <= afe.fsk_demod_bit;
      if (rx_state_reg == cie_pkg::RX_DATA && full_bit) begin
        fsk_bit_clock <= 1'b1;
      end else if (half_bit) begin
        fsk_bit_clock <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // event flags
  // ****************************************************************
  logic [3:0] flag_reg;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  logic       ring_d_reg;
  logic       alert_q_d_reg;
  logic       byte_d_reg;
  logic       comb_reg;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ring_d_reg    <= 1'b0;
      alert_q_d_reg <= 1'b0;
      dt_q_d_reg    <= 1'b0;
      byte_d_reg    <= 1'b0;
    end else begin
      ring_d_reg    <= afe.ring_envelope;
      alert_q_d_reg <= alert_tone_qualified;
      dt_q_d_reg    <= dual_tone_valid;
      byte_d_reg    <= fsk_byte_ready;
    end
  end

  assign flag_set[cie_pkg::FLG_RING]  = afe.ring_envelope & ~ring_d_reg;
  assign flag_set[cie_pkg::FLG_ALERT] = alert_tone_qualified
                                      & ~alert_q_d_reg;
  assign flag_set[cie_pkg::FLG_DT]    = dual_tone_valid & ~dt_q_d_reg;
  assign flag_set[cie_pkg::FLG_BYTE]  = fsk_byte_ready & ~byte_d_reg;
  assign flag_clr = (bus.wr && bus.addr == cie_pkg::ADDR_FLAGS)
                  ? bus.wdata[3:0] : 4'h0;

  // a set arriving with its clear wins, so no event is lost
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      flag_reg <= '0;
      comb_reg <= 1'b0;
    end else begin
      flag_reg <= (flag_reg & ~flag_clr) | flag_set;
      if (|flag_set) begin
        comb_reg <= 1'b1;
      end else if (bus.wr && bus.addr == cie_pkg::ADDR_FLAGS
                   && bus.wdata[cie_pkg::FLG_COMBINED]) begin
        comb_reg <= 1'b0;
      end
    end
  end

  assign combined_irq_flag = comb_reg | (|flag_reg);

  // ****************************************************************
  // read port
  // ****************************************************************
  logic [7:0] status;
  logic [7:0] flags_rd;
  logic [7:0] dt_rd;

  always_comb begin
    status = '0;
    status[cie_pkg::ST_ALERT_Q]  = alert_tone_qualified;
    status[cie_pkg::ST_DT_VALID] = dual_tone_valid;
    status[cie_pkg::ST_CARRIER]  = carrier_detect;
    status[cie_pkg::ST_SER_BIT]  = fsk_serial_bit;
    status[cie_pkg::ST_BIT_CLK]  = fsk_bit_clock;
    status[cie_pkg::ST_BYTE_RDY] = fsk_byte_ready;
    status[cie_pkg::ST_RING_ENV] = ring_d_reg;
    flags_rd = {4'h0, flag_reg};
    flags_rd[cie_pkg::FLG_COMBINED] = combined_irq_flag;
    dt_rd = {4'h0, dt_code_reg};
    dt_rd[cie_pkg::DTD_LOW_GRP]  = low_group_present;
    dt_rd[cie_pkg::DTD_HIGH_GRP] = high_group_present;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst || !bus.rd) begin
      rd_data <= '0;
    end else if (bus.addr == cie_pkg::ADDR_CTRL) begin
      rd_data <= ctrl_reg;
    end else if (bus.addr == cie_pkg::ADDR_FLAGS) begin
      rd_data <= flags_rd;
    end else if (bus.addr == cie_pkg::ADDR_STATUS) begin
      rd_data <= status;
    end else if (bus.addr == cie_pkg::ADDR_FSK_DATA) begin
      rd_data <= fsk_data_register;
    end else if (bus.addr == cie_pkg::ADDR_DT_DATA) begin
      rd_data <= dt_rd;
    end else if (bus.addr == cie_pkg::ADDR_AL_PT) begin
      rd_data <= alert_present_guard_reg;
    end else if (bus.addr == cie_pkg::ADDR_AL_AT) begin
      rd_data <= alert_absent_guard_reg;
    end else if (bus.addr == cie_pkg::ADDR_DT_PT) begin
      rd_data <= dual_tone_present_guard_reg;
    end else if (bus.addr == cie_pkg::ADDR_DT_AT) begin
      rd_data <= dual_tone_absent_guard_reg;
    end else if (bus.addr == cie_pkg::ADDR_DT_CFG2) begin
      rd_data <= dual_tone_config_two_reg;
    end else begin
      rd_data <= '0;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_global_gate_off: assert property (
    !ctrl_reg[cie_pkg::CTRL_GLOBAL] |=> !alert_tone_qualified
      && !dual_tone_valid && !carrier_detect)
    else $error("detector active with global enable low");
  a_ring_flag_set: assert property (
    $rose(afe.ring_envelope) |=> flag_reg[cie_pkg::FLG_RING]
      ##0 combined_irq_flag)
    else $error("ring rise did not set ring flag");
  a_guard_restart: assert property (
    alert_on && $rose(afe.alert_tone_raw) ##1 alert_on
      |-> g_cnt_reg[0] == 8'h00 && g_run_reg[0])
    else $error("guard timer not restarted on raw rise");
  a_guard_tick_only: assert property (
    g_run_reg[0] && !tick && $stable(g_raw[0]) && alert_on
      |=> $stable(g_cnt_reg[0]))
    else $error("guard count moved without tick");
  a_qual_on_tick: assert property (
    $rose(alert_tone_qualified) |-> $past(tick)
      && $past(g_cnt_reg[0]) == $past(alert_present_guard_reg))
    else $error("alert qualified without guard match");
  a_alert_flag_set: assert property (
    $rose(alert_tone_qualified) |=> flag_reg[cie_pkg::FLG_ALERT])
    else $error("alert flag not set");
  a_dt_flag_code: assert property (
    $rose(dual_tone_valid) |-> dt_code_reg == $past(afe.dual_tone_code)
      ##1 flag_reg[cie_pkg::FLG_DT])
    else $error("dual tone code or flag wrong");
  a_tone_follow: assert property (
    dual_tone_on && tone_mode ##1 dual_tone_on && tone_mode
      |-> low_group_present == $past(afe.low_energy)
      && high_group_present == $past(afe.high_energy))
    else $error("group present bit lagging energy");
  a_cd_hold: assert property (
    $changed(carrier_detect) && fsk_decoder_on
      |-> $past(cd_cnt_reg) >= 20'(CARRIER_CYCLES - 1))
    else $error("carrier detect changed too early");
  a_byte_load: assert property (
    $rose(fsk_byte_ready) |-> fsk_data_register == $past(shift_reg)
      ##1 flag_reg[cie_pkg::FLG_BYTE])
    else $error("byte not loaded with ready");
  a_comb_any: assert property (
    (|flag_reg) |-> combined_irq_flag)
    else $error("combined flag low with a flag set");

  c_alert_qual: cover property ($rose(alert_tone_qualified));
  c_dt_valid:   cover property ($rose(dual_tone_valid));
  c_byte_rdy:   cover property ($rose(fsk_byte_ready));
  c_set_clear:  cover property (|(flag_set & flag_clr));

endmodule // cie_event_logic
`default_nettype wire

// >>> cie_pkg.sv
// constants and carrier types of the caller id event logic
`default_nettype none
package cie_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS    = 10000;
  localparam int GUARD_TICK_PS    = 858000000;
  localparam int CARRIER_TIME_US  = 8000;
  localparam int BAUD_RATE        = 1200;
  localparam int CLK_HZ           = 100000000;
  localparam int GUARD_TICK_CYC   = GUARD_TICK_PS / CLK_PERIOD_PS;
  localparam int CARRIER_CYC      =
    (CARRIER_TIME_US * 100 + CLK_PERIOD_PS / 10000 - 1)
    / (CLK_PERIOD_PS / 10000);
  localparam int BAUD_CYC         = CLK_HZ / BAUD_RATE;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_FLAGS    = 8'h01;
  localparam logic [7:0] ADDR_STATUS   = 8'h02;
  localparam logic [7:0] ADDR_FSK_DATA = 8'h03;
  localparam logic [7:0] ADDR_DT_DATA  = 8'h04;
  localparam logic [7:0] ADDR_AL_PT    = 8'h05;
  localparam logic [7:0] ADDR_AL_AT    = 8'h06;
  localparam logic [7:0] ADDR_DT_PT    = 8'h07;
  localparam logic [7:0] ADDR_DT_AT    = 8'h08;
  localparam logic [7:0] ADDR_DT_CFG2  = 8'h09;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_FSK_EN   = 0;
  localparam int CTRL_ALERT_EN = 1;
  localparam int CTRL_DT_EN    = 2;
  localparam int CTRL_GLOBAL   = 3;
  localparam int FLG_RING      = 0;
  localparam int FLG_ALERT     = 1;
  localparam int FLG_DT        = 2;
  localparam int FLG_BYTE      = 3;
  localparam int FLG_COMBINED  = 7;
  localparam int ST_ALERT_Q    = 0;
  localparam int ST_DT_VALID   = 1;
  localparam int ST_CARRIER    = 2;
  localparam int ST_SER_BIT    = 3;
  localparam int ST_BIT_CLK    = 4;
  localparam int ST_BYTE_RDY   = 5;
  localparam int ST_RING_ENV   = 6;
  localparam int DTD_LOW_GRP   = 4;
  localparam int DTD_HIGH_GRP  = 5;
  localparam int CFG2_TONE_MODE = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic       ring_envelope;
    logic       alert_tone_raw;
    logic       dual_tone_raw;
    logic [3:0] dual_tone_code;
    logic       high_energy;
    logic       low_energy;
    logic       fsk_band_energy;
    logic       fsk_demod_bit;
  } cie_afe_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cie_bus_t;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } cie_rx_state_t;
endpackage
`default_nettype wire

// >>> cie_pkg_dummy_never.sv
// empty companion file: all logic lives in the event logic module
`default_nettype none
`default_nettype wire

// >>> tb.sv
// self-checking bench of the caller id event logic
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic              core_clk = 1'b0;
  logic              nrst     = 1'b0;
  cie_pkg::cie_bus_t bus      = '0;
  cie_pkg::cie_afe_t afe;
  logic [7:0]        rd_data;
  logic              irq, fsk_on, al_on, dt_on;
  int                mismatches = 0;
  int                check_count = 0;
  int                cyc = 0;
  logic [7:0]        rc [6] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0c, 8'h0f};
  logic [2:0]        re [6] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
  // short counts keep the run brief
  cie_event_logic #(.GUARD_TICK_CYCLES(4), .CARRIER_CYCLES(10),
    .BAUD_CYCLES(16)) dut (.core_clk(core_clk), .nrst(nrst), .bus(bus),
    .rd_data(rd_data), .afe(afe), .combined_irq_flag(irq),
    .fsk_decoder_on(fsk_on), .alert_on(al_on), .dual_tone_on(dt_on));
  cie_afe_model #(.BAUD(16)) afe_m (.core_clk(core_clk), .afe(afe));
  always #5 core_clk = ~core_clk;
  // ****************************************************************
  // bus tasks and compare
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] exp);
    @(posedge core_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1 chk(rd_data & m, exp);
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles needed
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      print_verdict();
    end
  end
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    #1 chk({rd_data[7:1], irq}, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(cie_pkg::ADDR_CTRL, rc[i]);
      #1 chk({5'h00, dt_on, al_on, fsk_on}, {5'h00, re[i]});
    end
    wr(cie_pkg::ADDR_CTRL, 8'h00);
    afe_m.afe.ring_envelope <= 1'b1;
    rdc(cie_pkg::ADDR_FLAGS, 8'hff, 8'h81);
    wr(cie_pkg::ADDR_FLAGS, 8'h8f);
    rdc(cie_pkg::ADDR_FLAGS, 8'hff, 8'h00);
    wr(cie_pkg::ADDR_AL_PT, 8'h02);
    wr(cie_pkg::ADDR_AL_AT, 8'h01);
    wr(cie_pkg::ADDR_CTRL, 8'h0a);
    afe_m.afe.alert_tone_raw <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdc(cie_pkg::ADDR_STATUS, 8'h01, 8'h00);
    repeat (12) @(posedge core_clk);
    wr(cie_pkg::ADDR_STATUS, 8'h00);
    rdc(cie_pkg::ADDR_STATUS, 8'h01, 8'h01);
    afe_m.afe.alert_tone_raw <= 1'b0;
    repeat (14) @(posedge core_clk);
    rdc(cie_pkg::ADDR_STATUS, 8'h01, 8'h00);
    rdc(cie_pkg::ADDR_FLAGS, 8'hff, 8'h82);
    wr(cie_pkg::ADDR_FLAGS, 8'h8f);
    wr(cie_pkg::ADDR_DT_PT, 8'h01);
    wr(cie_pkg::ADDR_DT_AT, 8'h01);
    wr(cie_pkg::ADDR_CTRL, 8'h0c);
    afe_m.afe.dual_tone_code <= 4'h9;
    afe_m.afe.dual_tone_raw <= 1'b1;
    repeat (14) @(posedge core_clk);
    rdc(cie_pkg::ADDR_DT_DATA, 8'h0f, 8'h09);
    rdc(cie_pkg::ADDR_STATUS, 8'h02, 8'h02);
    rdc(cie_pkg::ADDR_FLAGS, 8'hff, 8'h84);
    afe_m.afe.dual_tone_raw <= 1'b0;
    wr(cie_pkg::ADDR_DT_CFG2, 8'h10);
    afe_m.afe.high_energy <= 1'b1;
    rdc(cie_pkg::ADDR_DT_DATA, 8'h30, 8'h20);
    wr(cie_pkg::ADDR_CTRL, 8'h09);
    afe_m.afe.fsk_band_energy <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdc(cie_pkg::ADDR_STATUS, 8'h04, 8'h00);
    repeat (8) @(posedge core_clk);
    rdc(cie_pkg::ADDR_STATUS, 8'h04, 8'h04);
    wr(cie_pkg::ADDR_FLAGS, 8'h8f);
    // status polled mid frame: bit clock high in bit 0, low in bit 1
    fork
      afe_m.send_byte(8'ha5);
      begin
        repeat (28) @(posedge core_clk);
        rdc(cie_pkg::ADDR_STATUS, 8'h18, 8'h18);
        repeat (7) @(posedge core_clk);
        rdc(cie_pkg::ADDR_STATUS, 8'h18, 8'h00);
      end
    join
    repeat (4) @(posedge core_clk);
    rdc(cie_pkg::ADDR_FSK_DATA, 8'hff, 8'ha5);
    rdc(cie_pkg::ADDR_STATUS, 8'h20, 8'h20);
    rdc(cie_pkg::ADDR_FLAGS, 8'hff, 8'h88);
    chk({7'h00, irq}, 8'h01);
    afe_m.afe.fsk_band_energy <= 1'b0;
    repeat (4) @(posedge core_clk);
    rdc(cie_pkg::ADDR_STATUS, 8'h04, 8'h04);
    repeat (14) @(posedge core_clk);
    rdc(cie_pkg::ADDR_STATUS, 8'h04, 8'h00);
    // mid-run reset with ring low, so release shows no edge
    afe_m.afe.ring_envelope <= 1'b0;
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rdc(cie_pkg::ADDR_FLAGS, 8'hff, 8'h00);
    rdc(cie_pkg::ADDR_CTRL, 8'hff, 8'h00);
    chk({7'h00, irq}, 8'h00);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
